/* File: pkg/support_pkg.sv */
// Summary of operation
// - CRC starts from preset 0000h, 6363h, A671h or FFFFh per 2-bit select.
// - CRC uses fixed polynomial x^16+x^12+x^5+1, sixteen bits wide.
// - CRC result is read as separate high and low byte registers.
// - Bit-order bit set feeds bytes MSB first, else LSB first.
// - One shared FIFO of 64 bytes serves host and internal machines.
// - Host write to queue data port stores a byte, advances write pointer.
// - Host read of queue data port returns head byte, advances read pointer.
// - Fill register reads stored byte count in seven bits.
// - Flush resets pointers, zeroes level, clears overflow error.
// - Overflow error stays set until a flush.
// - Almost full is high when 64 minus level is at most watermark.
// - Almost empty is high when level is at most watermark.
// - Rising almost full or empty sets its flag; enabled flags drive IRQ.
// - Any pending flag sets the summary status bit; enabled ones drive IRQ.
// - Transmit done flag is set when data ends and frame end starts.
// - CRC sets done flag and complete bit after draining the FIFO.
// - Receive end sets receive flag; command return to idle sets done flag.
// - Error flag is set while any error register bit is one.
// - Timer has 12-bit prescaler, 16-bit reload counter, readable live value.
// - Counter reaching zero sets timer flag, then stops or reloads.
// - Host starts or stops the timer, or enables protocol start.
// - Total period is (2P+1)*R+1 ticks, or (2P+2)*R+1 if even.
// - Command code 0011 starts the CRC over the FIFO contents.
package support_pkg;
  localparam int          QDEPTH   = 64;
  localparam logic [6:0]  QFULL    = 7'h40;
  localparam logic [7:0]  A_CMD    = 8'h00;
  localparam logic [7:0]  A_IEN    = 8'h04;
  localparam logic [7:0]  A_IFLG   = 8'h08;
  localparam logic [7:0]  A_MFLG   = 8'h0c;
  localparam logic [7:0]  A_ERR    = 8'h10;
  localparam logic [7:0]  A_STAT   = 8'h14;
  localparam logic [7:0]  A_QDATA  = 8'h18;
  localparam logic [7:0]  A_QFILL  = 8'h1c;
  localparam logic [7:0]  A_WMARK  = 8'h20;
  localparam logic [7:0]  A_CTRL   = 8'h24;
  localparam logic [7:0]  A_MODE   = 8'h28;
  localparam logic [7:0]  A_TMODE  = 8'h2c;
  localparam logic [7:0]  A_TPRE   = 8'h30;
  localparam logic [7:0]  A_TRLH   = 8'h34;
  localparam logic [7:0]  A_TRLL   = 8'h38;
  localparam logic [7:0]  A_TCVH   = 8'h3c;
  localparam logic [7:0]  A_TCVL   = 8'h40;
  localparam logic [7:0]  A_CRCH   = 8'h44;
  localparam logic [7:0]  A_CRCL   = 8'h48;
  localparam int          B_SET    = 7;
  localparam int          B_FLUSH  = 7;
  localparam int          B_TSTART = 6;
  localparam int          B_TSTOP  = 7;
  localparam int          B_MSB    = 7;
  localparam int          B_TIMER_AUTO_START  = 7;
  localparam int          B_TRELD  = 5;
  localparam int          B_TEVEN  = 4;
  localparam int          B_CRCF   = 2;
  localparam logic [3:0]  CMD_IDLE = 4'h0;
  localparam logic [3:0]  CMD_CRC  = 4'h3;
  localparam logic [3:0]  CMD_KEEP = 4'h7;
  localparam logic [3:0][15:0] CRC_PRESETS = {16'hffff, 16'ha671, 16'h6363, 16'h0000};
  localparam logic [15:0] POLY_MSB = 16'h1021;
  localparam logic [15:0] POLY_LSB = 16'h8408;
  localparam logic [1:0]  R_OKAY   = 2'b00;
  localparam logic [1:0]  R_DECERR = 2'b11;

  typedef enum logic [0:0] {CRC_OFF = 1'b0, CRC_RUN = 1'b1} crc_st_t;

  // Events and bytes from the protocol machines, all on aclk.
  typedef struct packed {
    logic       tx_done;
    logic       rx_done;
    logic [3:0] err;
    logic       timer_trig;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       tx_req;
  } proto_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                           input logic msb);
    logic [15:0] r;
    logic        b;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (msb) begin
        b = d[7-i] ^ r[15];
        r = {r[14:0], 1'b0} ^ (b ? POLY_MSB : 16'h0000);
      end else begin
        b = d[i] ^ r[0];
        r = {1'b0, r[15:1]} ^ (b ? POLY_LSB : 16'h0000);
      end
    end
    return r;
  endfunction
endpackage

/* File: rtl/support_core.sv */
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module support_core
  import support_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Protocol side
  input  wire proto_t            proto,
  input  wire logic              timer_tick,
  output logic                   tx_byte_valid,
  output logic [7:0]             tx_byte,
  output logic                   irq
);

  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       awaddr;
    logic [7:0]       wdata;
    logic             wstrb0;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [3:0]       cmd;
    logic [7:0]       ien;
    logic [6:0]       iflags;
    logic             crc_flag;
    logic [3:0]       ext_err;
    logic             ovf;
    logic [5:0]       wm;
    logic [1:0]       crc_sel;
    logic             msb_first;
    crc_st_t          crc_st;
    logic [15:0]      crc;
    logic             crc_ok;
    logic [5:0]       wp;
    logic [5:0]       rp;
    logic [6:0]       lvl;
    logic [QDEPTH-1:0][7:0] mem;
    logic             hi_prev;
    logic             lo_prev;
    logic             irq;
    logic             t_auto;
    logic             t_reld;
    logic             t_even;
    logic [11:0]      presc;
    logic [15:0]      reload;
    logic [15:0]      tcnt;
    logic [12:0]      pcnt;
    logic             t_run;
    logic             t_load;
    logic             tx_valid;
    logic [7:0]       tx_byte;
  } state_t;

  state_t s_q;
  state_t s_d;

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;
  assign tx_byte_valid = s_q.tx_valid;
  assign tx_byte       = s_q.tx_byte;
  assign irq           = s_q.irq;

  logic        wr_go;
  logic        rd_go;
  logic [7:0]  ra;
  logic [7:0]  wd;
  logic        push_v;
  logic [7:0]  push_d;
  logic        pop_v;
  logic        push_ok;
  logic        pop_ok;
  logic        flush;
  logic        t_start;
  logic        t_stop;
  logic        t_exp;
  logic        hi_now;
  logic        lo_now;
  logic [6:0]  ev;
  logic [12:0] pre_top;

  always_comb begin
    s_d     = s_q;
    wr_go   = 1'b0;
    rd_go   = 1'b0;
    ra      = 8'h00;
    wd      = s_q.wdata;
    push_v  = 1'b0;
    push_d  = 8'h00;
    pop_v   = 1'b0;
    flush   = 1'b0;
    t_start = 1'b0;
    t_stop  = 1'b0;
    t_exp   = 1'b0;
    ev      = 7'h00;
    pre_top = {s_q.presc, 1'b0} + {12'h000, s_q.t_even};
    s_d.tx_valid = 1'b0;

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awready = 1'b0;
      s_d.aw_have = 1'b1;
      s_d.awaddr  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wready  = 1'b0;
      s_d.w_have  = 1'b1;
      s_d.wdata   = s_axi_wdata[7:0];
      s_d.wstrb0  = s_axi_wstrb[0];
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      wr_go       = s_q.wstrb0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = R_OKAY;
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      if (s_q.awaddr[1:0] != 2'b00 || s_q.awaddr > A_CRCL) begin
        s_d.bresp = R_DECERR;
        wr_go     = 1'b0;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // Host register writes.
    if (wr_go) begin
      unique case (s_q.awaddr)
        A_CMD: begin
          if (wd[3:0] == CMD_CRC) begin
            s_d.cmd    = CMD_CRC;
            s_d.crc_st = CRC_RUN;
            s_d.crc    = CRC_PRESETS[s_q.crc_sel];
            s_d.crc_ok = 1'b0;
          end else if (wd[3:0] != CMD_KEEP) begin
            s_d.cmd    = wd[3:0];
            s_d.crc_st = CRC_OFF;
          end
        end
        A_IEN: s_d.ien = wd;
        A_IFLG: begin
          if (wd[B_SET]) begin
            s_d.iflags = s_q.iflags | wd[6:0];
          end else begin
            s_d.iflags = s_q.iflags & ~wd[6:0];
          end
        end
        A_MFLG: begin
          if (wd[B_CRCF]) begin
            s_d.crc_flag = wd[B_SET];
          end
        end
        A_ERR: s_d.ext_err = s_q.ext_err & ~wd[3:0];
        A_QDATA: begin
          push_v = 1'b1;
          push_d = wd;
        end
        A_QFILL: flush = wd[B_FLUSH];
        A_WMARK: s_d.wm = wd[5:0];
        A_CTRL: begin
          t_start = wd[B_TSTART];
          t_stop  = wd[B_TSTOP];
        end
        A_MODE: begin
          s_d.crc_sel   = wd[1:0];
          s_d.msb_first = wd[B_MSB];
        end
        A_TMODE: begin
          s_d.t_auto       = wd[B_TIMER_AUTO_START];
          s_d.t_reld       = wd[B_TRELD];
          s_d.t_even       = wd[B_TEVEN];
          s_d.presc[11:8]  = wd[3:0];
        end
        A_TPRE: s_d.presc[7:0]   = wd;
        A_TRLH: s_d.reload[15:8] = wd;
        A_TRLL: s_d.reload[7:0]  = wd;
        default: ;
      endcase
    end

    // Read channel.
    if (s_axi_arvalid && s_q.arready) begin
      rd_go       = 1'b1;
      ra          = s_axi_araddr[7:0];
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = R_OKAY;
      s_d.rdata   = 32'h0000_0000;
      unique case (ra)
        A_CMD:   s_d.rdata[3:0] = s_q.cmd;
        A_IEN:   s_d.rdata[7:0] = s_q.ien;
        A_IFLG:  s_d.rdata[6:0] = s_q.iflags;
        A_MFLG:  s_d.rdata[B_CRCF] = s_q.crc_flag;
        A_ERR:   s_d.rdata[4:0] = {s_q.ovf, s_q.ext_err};
        A_STAT:  s_d.rdata[7:0] = {s_q.t_run, 1'b0, s_q.crc_ok,
                                   (|s_q.iflags) | s_q.crc_flag,
                                   2'b00, s_q.hi_prev, s_q.lo_prev};
        A_QDATA: begin
          s_d.rdata[7:0] = s_q.mem[s_q.rp];
          pop_v = rd_go && (s_q.crc_st == CRC_OFF);
        end
        A_QFILL: s_d.rdata[6:0] = s_q.lvl;
        A_WMARK: s_d.rdata[5:0] = s_q.wm;
        A_MODE:  s_d.rdata[7:0] = {s_q.msb_first, 5'h00, s_q.crc_sel};
        A_TMODE: s_d.rdata[7:0] = {s_q.t_auto, 1'b0, s_q.t_reld, s_q.t_even,
                                   s_q.presc[11:8]};
        A_TPRE:  s_d.rdata[7:0] = s_q.presc[7:0];
        A_TRLH:  s_d.rdata[7:0] = s_q.reload[15:8];
        A_TRLL:  s_d.rdata[7:0] = s_q.reload[7:0];
        A_TCVH:  s_d.rdata[7:0] = s_q.tcnt[15:8];
        A_TCVL:  s_d.rdata[7:0] = s_q.tcnt[7:0];
        A_CRCH:  s_d.rdata[7:0] = s_q.crc[15:8];
        A_CRCL:  s_d.rdata[7:0] = s_q.crc[7:0];
        A_CTRL:  s_d.rdata = 32'h0000_0000;
        default: s_d.rresp = R_DECERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    // The receiver may only push when the host is not writing the queue.
    if (!push_v && proto.rx_valid) begin
      push_v = 1'b1;
      push_d = proto.rx_byte;
    end

    // CRC engine drains one byte a cycle; host reads then see the head only.
    if (s_q.crc_st == CRC_RUN) begin
      if (s_q.lvl != 7'h00) begin
        pop_v = 1'b1;
        s_d.crc = crc_byte(s_q.crc, s_q.mem[s_q.rp], s_q.msb_first);
      end else begin
        s_d.crc_st   = CRC_OFF;
        s_d.crc_ok   = 1'b1;
        s_d.crc_flag = 1'b1;
        s_d.cmd      = CMD_IDLE;
      end
    end else if (proto.tx_req && !pop_v && s_q.lvl != 7'h00) begin
      pop_v        = 1'b1;
      s_d.tx_valid = 1'b1;
      s_d.tx_byte  = s_q.mem[s_q.rp];
    end

    // Shared queue.
    push_ok = push_v && (s_q.lvl != QFULL);
    pop_ok  = pop_v && (s_q.lvl != 7'h00);
    if (push_ok) begin
      s_d.mem[s_q.wp] = push_d;
      s_d.wp = s_q.wp + 6'h01;
    end
    if (pop_ok) begin
      s_d.rp = s_q.rp + 6'h01;
    end
    s_d.lvl = s_q.lvl + {6'h00, push_ok} - {6'h00, pop_ok};
    if (flush) begin
      s_d.wp  = 6'h00;
      s_d.rp  = 6'h00;
      s_d.lvl = 7'h00;
      s_d.ovf = 1'b0;
    end
    if (push_v && !push_ok) begin
      s_d.ovf = 1'b1;
    end
    s_d.ext_err = s_d.ext_err | proto.err;

    // Timer: start, stop and two counting stages on the tick enable.
    if (s_q.t_auto && proto.timer_trig) begin
      t_start = 1'b1;
    end
    if (t_start) begin
      s_d.t_run  = 1'b1;
      s_d.t_load = 1'b1;
    end
    if (s_q.t_run && timer_tick && !t_start) begin
      if (s_q.t_load) begin
        s_d.t_load = 1'b0;
        s_d.tcnt   = s_q.reload;
        s_d.pcnt   = pre_top;
        t_exp      = (s_q.reload == 16'h0000);
      end else if (s_q.pcnt != 13'h0000) begin
        s_d.pcnt = s_q.pcnt - 13'h0001;
      end else begin
        s_d.pcnt = pre_top;
        s_d.tcnt = s_q.tcnt - 16'h0001;
        t_exp    = (s_q.tcnt == 16'h0001);
      end
      if (t_exp) begin
        s_d.t_load = s_q.t_reld;
        s_d.t_run  = s_q.t_reld;
      end
    end
    if (t_stop) begin
      s_d.t_run  = 1'b0;
      s_d.t_load = 1'b0;
    end

    // Alerts from the new level.
    hi_now = ((QFULL - s_d.lvl) <= {1'b0, s_d.wm});
    lo_now = (s_d.lvl <= {1'b0, s_d.wm});
    s_d.hi_prev = hi_now;
    s_d.lo_prev = lo_now;

    // Events set flags after any host clear, so a coinciding event wins.
    ev[0] = t_exp;
    ev[1] = s_d.ovf | (|s_d.ext_err);
    ev[2] = lo_now & ~s_q.lo_prev;
    ev[3] = hi_now & ~s_q.hi_prev;
    ev[4] = (s_q.cmd != CMD_IDLE) && (s_d.cmd == CMD_IDLE);
    ev[5] = proto.rx_done;
    ev[6] = proto.tx_done;
    s_d.iflags = s_d.iflags | ev;
    s_d.irq = |({s_d.crc_flag, s_d.iflags} & s_d.ien);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.lo_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* File: sim/core_props.sv */
`timescale 1ns/1ps
module core_props
  import support_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Protocol side
  input wire logic        tx_byte_valid,
  input wire logic [7:0]  tx_byte
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Reads off the aligned map must be refused, and only those.
  logic rd_bad;
  assign rd_bad = (s_axi_araddr[1:0] != 2'b00) || (s_axi_araddr > A_CRCL);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (s_wtake |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_WR_BUSY: assert property (s_wtake |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken twice");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer stuck");
  AST_RD_ANSWER: assert property (s_rtake |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer stuck");
  AST_R_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte");
  AST_R_RESP: assert property (s_rtake ##0 rd_bad |=> s_axi_rresp == R_DECERR)
    else $error("read off the map not refused");
  AST_R_OKAY: assert property (s_rtake ##0 !rd_bad |=> s_axi_rresp == R_OKAY)
    else $error("mapped read refused");
  AST_TX_HOLD: assert property ($changed(tx_byte) |-> tx_byte_valid)
    else $error("transmit byte moved without strobe");
endmodule

bind support_core core_props u_props (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte)
);

/* File: sim/far_side.sv */
`timescale 1ns/1ps
module far_side
  import support_pkg::*;
(
  // Clock
  input wire logic       aclk,
  // Toward the core
  output proto_t         proto,
  output logic           timer_tick,
  // From the core
  input wire logic       tx_byte_valid,
  input wire logic [7:0] tx_byte
);
  logic [7:0] got;
  initial begin
    proto = '0;
    timer_tick = 1'b0;
    got = 8'h00;
  end
  always @(posedge aclk) begin
    if (tx_byte_valid) got <= tx_byte;
  end
  // Events last one cycle, as the protocol machines raise them.
  task automatic pulse(input proto_t p);
    @(posedge aclk);
    proto <= p;
    @(posedge aclk);
    proto <= '0;
  endtask
  // Spaced ticks, so that a slip of one tick shows in the count.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      timer_tick <= 1'b1;
      @(posedge aclk);
      timer_tick <= 1'b0;
    end
  endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import support_pkg::*;
;
  typedef struct packed {
    logic [7:0] m;
    logic [1:0] rs;
    logic [7:0] e;
  } note_t;
  localparam int WM = 4;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr, tx_byte, v, b;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        tx_byte_valid, irq, timer_tick;
  proto_t      proto, p;
  note_t       mon_n;
  note_t       exp_q[$];
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [7:0]  d[64];
  logic [15:0] c;
  logic [15:0] pre[4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};

  support_core #(.ADDR_W(8)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .proto(proto),
    .timer_tick(timer_tick), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
    .irq(irq)
  );
  far_side u_far (
    .aclk(aclk), .proto(proto), .timer_tick(timer_tick),
    .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    awaddr <= a;
    wdata <= {24'h0, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                    input logic [1:0] rs = R_OKAY);
    exp_q.push_back(note_t'{m, rs, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata[7:0];
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic [15:0] crc_ref(input logic [15:0] r, input logic [7:0] x,
                                          input logic m);
    for (int i = 0; i < 8; i++) begin
      if (m) r = (r[15] ^ x[7-i]) ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
      else r = (r[0] ^ x[i]) ? {1'b0, r[15:1]} ^ 16'h8408 : {1'b0, r[15:1]};
    end
    return r;
  endfunction

  always @(posedge aclk) begin
    if (aresetn && rvalid && rready) begin
      mon_n = exp_q.pop_front();
      chk({rresp, rdata[7:0] & mon_n.m}, {mon_n.rs, mon_n.e & mon_n.m});
    end
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    void'($urandom(72940));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_QFILL, 8'h00, 8'hff);
    rd(A_STAT, 8'h01, 8'hff);
    rd(8'h4c, 8'h00, 8'h00, R_DECERR);
    $display("reset test done");
    wr(A_WMARK, 8'(WM));
    for (int i = 0; i < 64; i++) begin
      d[i] = 8'($urandom);
      wr(A_QDATA, d[i]);
    end
    rd(A_QFILL, 8'h40, 8'hff);
    rd(A_IFLG, 8'h08, 8'h08);
    chk({9'h0, irq}, 10'h000);
    wr(A_QDATA, 8'h5a);
    rd(A_ERR, 8'h10, 8'h10);
    for (int i = 0; i < 60; i++) begin
      if (i < 6 || i > 57) rd(A_STAT, {6'h0, i <= WM, 64 - i <= WM}, 8'h03);
      rd(A_QDATA, d[i], 8'hff);
    end
    rd(A_ERR, 8'h10, 8'h10);
    rd(A_IFLG, 8'h04, 8'h04);
    wr(A_QFILL, 8'h80);
    rd(A_QFILL, 8'h00, 8'hff);
    rd(A_ERR, 8'h00, 8'h10);
    $display("queue test done");
    wr(A_QDATA, 8'h3c);
    p = '0;
    p.tx_req = 1'b1;
    u_far.pulse(p);
    repeat (2) @(posedge aclk);
    chk({2'h0, u_far.got}, 10'h03c);
    p = '0;
    p.rx_valid = 1'b1;
    p.rx_byte = 8'hc3;
    u_far.pulse(p);
    rd(A_QDATA, 8'hc3, 8'hff);
    p = '0;
    p.err = 4'h5;
    u_far.pulse(p);
    rd(A_ERR, 8'h05, 8'h0f);
    rd(A_IFLG, 8'h02, 8'h02);
    wr(A_ERR, 8'h0f);
    wr(A_IFLG, 8'h7f);
    rd(A_STAT, 8'h00, 8'h10);
    p = '0;
    p.tx_done = 1'b1;
    p.rx_done = 1'b1;
    u_far.pulse(p);
    rd(A_IFLG, 8'h60, 8'h60);
    rd(A_STAT, 8'h10, 8'h10);
    $display("shared queue test done");
    for (int k = 0; k < 8; k++) begin
      wr(A_MODE, {k[2], 5'h0, k[1:0]});
      wr(A_QFILL, 8'h80);
      c = pre[k[1:0]];
      for (int j = 0; j < 3; j++) begin
        b = 8'($urandom);
        c = crc_ref(c, b, k[2]);
        wr(A_QDATA, b);
      end
      wr(A_CMD, {4'h0, CMD_CRC});
      v = 8'h00;
      for (int t = 0; t < 20 && !v[5]; t++) rd(A_STAT, 8'h00, 8'h00);
      rd(A_STAT, 8'h20, 8'h20);
      rd(A_MFLG, 8'h04, 8'h04);
      rd(A_IFLG, 8'h10, 8'h10);
      rd(A_CRCH, c[15:8], 8'hff);
      rd(A_CRCL, c[7:0], 8'hff);
      wr(A_MFLG, 8'h04);
      wr(A_IFLG, 8'h10);
    end
    $display("crc test done");
    wr(A_IEN, 8'h01);
    for (int e = 0; e < 2; e++) begin
      wr(A_IFLG, 8'h7f);
      wr(A_TMODE, {3'h0, e[0], 4'h0});
      wr(A_TPRE, 8'h01);
      wr(A_TRLH, 8'h00);
      wr(A_TRLL, 8'h02);
      wr(A_CTRL, 8'h40);
      u_far.ticks(6 + 2 * e);
      rd(A_IFLG, 8'h00, 8'h01);
      rd(A_STAT, 8'h80, 8'h80);
      u_far.ticks(1);
      rd(A_IFLG, 8'h01, 8'h01);
      rd(A_STAT, 8'h10, 8'h90);
      rd(A_TCVL, 8'h00, 8'hff);
      chk({9'h0, irq}, 10'h001);
    end
    wr(A_CTRL, 8'h40);
    u_far.ticks(2);
    wr(A_CTRL, 8'h80);
    rd(A_STAT, 8'h00, 8'h80);
    wr(A_TMODE, 8'ha0);
    wr(A_IFLG, 8'h7f);
    p = '0;
    p.timer_trig = 1'b1;
    u_far.pulse(p);
    u_far.ticks(7);
    rd(A_IFLG, 8'h01, 8'h01);
    rd(A_STAT, 8'h80, 8'h80);
    wr(A_IFLG, 8'h01);
    u_far.ticks(6);
    rd(A_IFLG, 8'h00, 8'h01);
    u_far.ticks(1);
    rd(A_IFLG, 8'h01, 8'h01);
    wr(A_CTRL, 8'h80);
    wr(A_IFLG, 8'h01);
    wr(A_IFLG, 8'h81);
    rd(A_IFLG, 8'h01, 8'h01);
    $display("timer test done");
    report_and_stop();
  end
endmodule
